// ===== logic/dts_defines.vh
// Purpose: shared constants for the dma transfer sequencer
// Assumes: included by bare name from logic/
// Notes: timing counts are in clock cycles
`ifndef DTS_DEFINES_VH
`define DTS_DEFINES_VH
// =====================================
// command bits
`define DTS_CMD_MEM2MEM_BIT 0
`define DTS_CMD_HOLD_SRC_BIT 1
`define DTS_CMD_DISABLE_BIT 2
`define DTS_CMD_COMPRESS_BIT 3
`define DTS_CMD_EXTWR_BIT 5
`define DTS_CMD_REQ_HIGH_BIT 6
`define DTS_CMD_ACK_HIGH_BIT 7
// =====================================
// transfer types (mode bits 3:2)
`define DTS_XFER_VERIFY 2'h0
`define DTS_XFER_WRITE 2'h1
`define DTS_XFER_READ 2'h2
// =====================================
// channel modes (decoded from mode bits 3:2, the same bits as the transfer type)
`define DTS_MODE_DEMAND 2'h0
`define DTS_MODE_SINGLE 2'h1
`define DTS_MODE_BLOCK 2'h2
`define DTS_MODE_CASCADE 2'h3
// =====================================
// counts and reset values
`define DTS_MIN_GRANT_WAIT 2'h2
`define DTS_COUNT_WRAP 16'hffff
`define DTS_COUNT_ZERO 16'h0000
`define DTS_CMD_RESET 8'h00
`define DTS_MASK_RESET 4'hf
`endif

// ===== logic/dts_chan_regs.v
// Purpose: one channel's current address and word count
// Assumes: loads come from the programming side, steps from the sequencer
// Notes: wrap flag is combinational from the count
`timescale 1ns/1ps
`include "dts_defines.vh"
module dts_chan_regs #(
   parameter AW = 16
) (
   // clock and reset
   input wire clk_i,
   input wire srst_i,
   // control
   input wire load_i,
   input wire [AW-1:0] load_addr_i,
   input wire [AW-1:0] load_count_i,
   input wire step_i,
   input wire addr_hold_i,
   input wire addr_down_i,
   // state
   output reg [AW-1:0] addr_o,
   output reg [AW-1:0] count_o,
   output wire at_zero_o
);
   assign at_zero_o = (count_o == `DTS_COUNT_ZERO);
   always @(posedge clk_i) begin
      if (srst_i) begin
         addr_o <= {AW{1'b0}};
         count_o <= {AW{1'b0}};
      end else if (load_i) begin
         addr_o <= load_addr_i;
         count_o <= load_count_i;
      end else if (step_i) begin
         count_o <= count_o - 1'b1; // RL18
         if (!addr_hold_i) begin
            if (addr_down_i) begin
               addr_o <= addr_o - 1'b1;
            end else begin
               addr_o <= addr_o + 1'b1;
            end
         end
      end
   end
endmodule

// ===== logic/dts_sequencer.v
// Purpose: four-channel dma transfer sequencer, bus hold and state timing
// Assumes: inputs synchronous to clk_i; registers loaded through plain ports
// Notes: states advance on rising edges of clk_i; pins split into in/out/oe
`timescale 1ns/1ps
`include "dts_defines.vh"
// Functional notes
// RL1: pulse end-of-process low on count wrap
// RL2: terminal count ends transfer, clears request
// RL3: system pulls unused end-of-process high
// RL4: low address pins input idle, output active
// RL5: host grants one cycle after request
// RL6: per-channel acknowledge, polarity programmable, none mem2mem
// RL7: address enable high while outputs valid
// RL8: strobe upper address from data bus
// RL9: every state lasts one clock, except grant wait and wait states
// RL10: idle samples requests, chip select, programming
// RL11: unmasked or software request raises hold request
// RL12: wait for grant, at least two clocks
// RL13: four states io, eight memory-to-memory
// RL14: ready low inserts wait states
// RL15: first state drives address, strobe, acknowledge
// RL16: skip first state if upper unchanged
// RL17: read strobe second, write third, compress skips
// RL18: fourth state: strobes off, count, address step
// RL19: read/write transfers pair memory and io strobes
// RL20: verify keeps strobes off, ignores ready
// RL21: channel 0 reads, channel 1 writes, both step
// RL22: command bits enable mem2mem, hold source
// RL23: peripheral holds request until acknowledge
// RL24: release bus outputs when not owner
module dts_sequencer #(
   parameter NCH = 4,
   parameter AW = 16
) (
   // clock and reset
   input wire clk_i,
   input wire srst_i,
   // configuration
   input wire [7:0] command_i,
   input wire [4*NCH-1:0] chan_mode_i,
   input wire [NCH-1:0] mask_i,
   input wire [NCH-1:0] soft_request_i,
   input wire [NCH-1:0] load_i,
   input wire [AW-1:0] load_addr_i,
   input wire [AW-1:0] load_count_i,
   // bus hold
   output wire bus_hold_request_o,
   input wire bus_hold_grant_i,
   // channel lines
   input wire [NCH-1:0] channel_request_i,
   output wire [NCH-1:0] channel_acknowledge_o,
   // host side
   input wire chip_select_n_i,
   input wire ready_i,
   output wire program_state_o,
   output wire [3:0] reg_select_o,
   // address and data pins
   input wire [3:0] low_address_pins_i,
   output wire [3:0] low_address_pins_o,
   output wire low_address_pins_oe_o,
   output wire [3:0] mid_address_pins_o,
   output wire mid_address_pins_oe_o,
   input wire [7:0] data_bus_pins_i,
   output wire [7:0] data_bus_pins_o,
   output wire data_bus_pins_oe_o,
   output wire address_valid_enable_o,
   output wire upper_address_strobe_o,
   // strobes
   output wire memory_read_strobe_n_o,
   output wire memory_write_strobe_n_o,
   output wire io_read_strobe_n_o,
   output wire io_write_strobe_n_o,
   output wire strobe_oe_o,
   // end of process (open drain)
   input wire end_of_process_n_i,
   output wire end_of_process_n_o,
   output wire end_of_process_n_oe_o,
   // status
   output wire [NCH-1:0] terminal_count_o,
   output wire [NCH-1:0] request_pending_o
);
   // =====================================
   // states
   localparam ST_IDLE = 3'h0;
   localparam ST_GRANT_WAIT = 3'h1;
   localparam ST_ADDR_OUT = 3'h2;
   localparam ST_READ = 3'h3;
   localparam ST_WRITE = 3'h4;
   localparam ST_END = 3'h5;
   localparam ST_WAIT = 3'h6;

   reg [2:0] state_reg, state_next;
   reg [1:0] chan_reg, chan_next;
   reg phase_reg, phase_next;
   reg [1:0] wait_cnt_reg, wait_cnt_next;
   reg [7:0] upper_reg, upper_next;
   reg upper_valid_reg, upper_valid_next;
   reg [7:0] hold_data_reg;
   reg [NCH-1:0] tc_reg, tc_next;
   reg [NCH-1:0] sreq_reg;
   reg eop_pulse_reg, eop_pulse_next;
   reg [2:0] after_wait_reg, after_wait_next;
   reg [NCH-1:0] step;
   reg [NCH-1:0] end_hit;

   wire [AW-1:0] addr [0:NCH-1];
   wire [AW-1:0] count [0:NCH-1];
   wire [NCH-1:0] at_zero;
   wire mem2mem = command_i[`DTS_CMD_MEM2MEM_BIT]; // RL22

   // =====================================
   // channel counters
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gen_ch
         dts_chan_regs #(.AW(AW)) u_regs (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .load_i(load_i[g]),
            .load_addr_i(load_addr_i),
            .load_count_i(load_count_i),
            .step_i(step[g]),
            .addr_hold_i((g == 0) && command_i[`DTS_CMD_HOLD_SRC_BIT] && mem2mem), // RL22
            .addr_down_i(chan_mode_i[4*g+1]),
            .addr_o(addr[g]),
            .count_o(count[g]),
            .at_zero_o(at_zero[g])
         );
      end
   endgenerate

   // =====================================
   // request qualification
   wire [NCH-1:0] req_act = command_i[`DTS_CMD_REQ_HIGH_BIT] ? ~channel_request_i : channel_request_i;
   wire [NCH-1:0] valid_req = ((req_act & ~mask_i) | sreq_reg) &
                              {NCH{~command_i[`DTS_CMD_DISABLE_BIT]}}; // RL11
   reg [1:0] pick;
   integer i;
   always @* begin
      pick = 2'h0;
      for (i = NCH - 1; i >= 0; i = i - 1) begin
         if (valid_req[i]) begin
            pick = i[1:0];
         end
      end
   end

   wire [1:0] cur_xfer = chan_mode_i[4*chan_reg+3 -: 2];
   wire [1:0] cur_cmode = {chan_mode_i[4*chan_reg+3], chan_mode_i[4*chan_reg+2]} & 2'h3;
   wire [1:0] act_chan = mem2mem ? {1'b0, phase_reg} : chan_reg; // RL21
   wire verify = !mem2mem && (cur_xfer == `DTS_XFER_VERIFY);
   wire cascade = (cur_cmode == `DTS_MODE_CASCADE);
   wire burst = (cur_cmode == `DTS_MODE_DEMAND) || (cur_cmode == `DTS_MODE_BLOCK);
   wire compress = command_i[`DTS_CMD_COMPRESS_BIT] && !mem2mem;
   wire ext_eop = !end_of_process_n_i && !cascade; // RL2
   wire cur_zero = at_zero[act_chan];
   wire [AW-1:0] cur_addr = addr[act_chan];
   // compare the stepped address: a carry into the upper byte needs a fresh strobe
   wire src_hold = (act_chan == 2'h0) && mem2mem && command_i[`DTS_CMD_HOLD_SRC_BIT];
   wire step_down = chan_mode_i[4*act_chan+1];
   wire [AW-1:0] next_addr = src_hold ? cur_addr : (step_down ? cur_addr - 1'b1 : cur_addr + 1'b1);
   wire upper_same = upper_valid_reg && (next_addr[15:8] == upper_reg); // RL16
   wire owns_bus = (state_reg != ST_IDLE) && (state_reg != ST_GRANT_WAIT);

   // =====================================
   // sequencer
   always @* begin
      state_next = state_reg;
      chan_next = chan_reg;
      phase_next = phase_reg;
      wait_cnt_next = wait_cnt_reg;
      upper_next = upper_reg;
      upper_valid_next = upper_valid_reg;
      tc_next = tc_reg;
      eop_pulse_next = 1'b0;
      after_wait_next = after_wait_reg;
      step = {NCH{1'b0}};
      end_hit = {NCH{1'b0}};
      case (state_reg) // RL9
         ST_IDLE: begin
            upper_valid_next = 1'b0;
            phase_next = 1'b0;
            wait_cnt_next = 2'h0;
            if (|valid_req) begin // RL10 RL11
               chan_next = mem2mem ? 2'h0 : pick;
               state_next = ST_GRANT_WAIT;
            end
         end
         ST_GRANT_WAIT: begin
            if (wait_cnt_reg != `DTS_MIN_GRANT_WAIT) begin
               wait_cnt_next = wait_cnt_reg + 2'h1;
            end
            if (bus_hold_grant_i && wait_cnt_reg >= `DTS_MIN_GRANT_WAIT - 2'h1) begin // RL12
               state_next = ST_ADDR_OUT;
            end
         end
         ST_ADDR_OUT: begin
            upper_next = cur_addr[15:8]; // RL15
            upper_valid_next = 1'b1;
            state_next = ST_READ;
         end
         ST_READ: begin
            if (!ready_i && !verify) begin // RL14 RL20
               after_wait_next = compress ? ST_END : ST_WRITE;
               state_next = ST_WAIT;
            end else begin
               state_next = compress ? ST_END : ST_WRITE; // RL17
            end
         end
         ST_WRITE: begin
            if (!ready_i && !verify) begin // RL14
               after_wait_next = ST_END;
               state_next = ST_WAIT;
            end else begin
               state_next = ST_END;
            end
         end
         ST_WAIT: begin
            if (ready_i) begin
               state_next = after_wait_reg;
            end
         end
         ST_END: begin
            step[act_chan] = 1'b1; // RL18 RL21
            // source count is ignored in mem2mem, only the destination wrap ends it
            if (cur_zero && !(mem2mem && !phase_reg)) begin
               eop_pulse_next = 1'b1; // RL1
            end
            if (mem2mem && !phase_reg) begin
               phase_next = 1'b1; // RL13
               state_next = (upper_valid_reg && addr[1][15:8] == upper_reg) ? ST_READ : ST_ADDR_OUT;
            end else if (cur_zero || ext_eop) begin
               tc_next[chan_reg] = 1'b1; // RL2
               end_hit[chan_reg] = 1'b1;
               state_next = ST_IDLE;
            end else if (mem2mem) begin
               phase_next = 1'b0;
               state_next = ST_ADDR_OUT;
            end else if (burst && valid_req[chan_reg]) begin
               state_next = upper_same ? ST_READ : ST_ADDR_OUT; // RL16
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (owns_bus && ext_eop && state_reg != ST_END) begin
         tc_next[chan_reg] = 1'b1; // RL2
         end_hit[chan_reg] = 1'b1;
         state_next = ST_IDLE;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= ST_IDLE;
         chan_reg <= 2'h0;
         phase_reg <= 1'b0;
         wait_cnt_reg <= 2'h0;
         upper_reg <= 8'h00;
         upper_valid_reg <= 1'b0;
         tc_reg <= {NCH{1'b0}};
         eop_pulse_reg <= 1'b0;
         after_wait_reg <= ST_IDLE;
         sreq_reg <= {NCH{1'b0}};
         hold_data_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         chan_reg <= chan_next;
         phase_reg <= phase_next;
         wait_cnt_reg <= wait_cnt_next;
         upper_reg <= upper_next;
         upper_valid_reg <= upper_valid_next;
         tc_reg <= tc_next;
         eop_pulse_reg <= eop_pulse_next;
         after_wait_reg <= after_wait_next;
         // software request set wins over terminal-count clear
         sreq_reg <= (sreq_reg & ~end_hit) | soft_request_i; // RL2
         if (mem2mem && !phase_reg && state_reg == ST_READ) begin
            hold_data_reg <= data_bus_pins_i; // RL21
         end
      end
   end

   // =====================================
   // outputs
   assign bus_hold_request_o = (state_reg != ST_IDLE); // RL11
   assign program_state_o = (state_reg == ST_IDLE) && !bus_hold_grant_i && !chip_select_n_i; // RL10
   assign reg_select_o = low_address_pins_i; // RL4
   wire ack_on = owns_bus && !mem2mem; // RL6
   wire [NCH-1:0] ack_vec = ack_on ? ({{(NCH-1){1'b0}}, 1'b1} << chan_reg) : {NCH{1'b0}};
   assign channel_acknowledge_o = command_i[`DTS_CMD_ACK_HIGH_BIT] ? ack_vec : ~ack_vec; // RL6
   assign address_valid_enable_o = owns_bus; // RL7
   assign upper_address_strobe_o = (state_reg == ST_ADDR_OUT); // RL8 RL15
   assign low_address_pins_o = cur_addr[3:0];
   assign mid_address_pins_o = cur_addr[7:4];
   assign low_address_pins_oe_o = owns_bus; // RL4 RL24
   assign mid_address_pins_oe_o = owns_bus; // RL4
   wire m2m_wr_data = owns_bus && mem2mem && phase_reg && state_reg != ST_ADDR_OUT;
   assign data_bus_pins_o = (state_reg == ST_ADDR_OUT) ? cur_addr[15:8] : hold_data_reg;
   assign data_bus_pins_oe_o = (state_reg == ST_ADDR_OUT) || m2m_wr_data; // RL8 RL24
   assign strobe_oe_o = owns_bus; // RL24
   wire in_read = (state_reg == ST_READ) || (state_reg == ST_WRITE) ||
                  (state_reg == ST_WAIT && after_wait_reg != ST_IDLE);
   wire ext_wr = command_i[`DTS_CMD_EXTWR_BIT];
   wire in_write = (state_reg == ST_WRITE) || (state_reg == ST_WAIT && after_wait_reg == ST_END) ||
                   ((ext_wr || compress) && state_reg == ST_READ); // RL17
   wire rd_side = !verify && in_read; // RL20
   wire wr_side = !verify && in_write;
   wire mem_rd = mem2mem ? (!phase_reg && rd_side) : (cur_xfer == `DTS_XFER_READ && rd_side); // RL19
   wire mem_wr = mem2mem ? (phase_reg && wr_side) : (cur_xfer == `DTS_XFER_WRITE && wr_side);
   wire io_rd = !mem2mem && cur_xfer == `DTS_XFER_WRITE && rd_side; // RL19
   wire io_wr = !mem2mem && cur_xfer == `DTS_XFER_READ && wr_side;
   assign memory_read_strobe_n_o = ~mem_rd; // RL18
   assign memory_write_strobe_n_o = ~mem_wr;
   assign io_read_strobe_n_o = ~io_rd;
   assign io_write_strobe_n_o = ~io_wr;
   assign end_of_process_n_o = 1'b0;
   assign end_of_process_n_oe_o = eop_pulse_reg; // RL1
   assign terminal_count_o = tc_reg;
   assign request_pending_o = valid_req;
endmodule

// ===== sim/dts_seq_properties.sv
// Purpose: timing checks on the sequencer ports
// Assumes: one clock, synchronous active-high reset
// Notes: acknowledge idle level is the inverse of command bit 7
`timescale 1ns/1ps
// ==========
// checker
module dts_seq_props #(
   parameter NCH = 4
) (
   // clock and reset
   input wire clk_i,
   input wire srst_i,
   // watched ports
   input wire [7:0] command_i,
   input wire [NCH-1:0] request_pending_o,
   input wire bus_hold_request_o,
   input wire [NCH-1:0] channel_acknowledge_o,
   input wire address_valid_enable_o,
   input wire upper_address_strobe_o,
   input wire data_bus_pins_oe_o,
   input wire low_address_pins_oe_o,
   input wire strobe_oe_o,
   input wire memory_read_strobe_n_o,
   input wire memory_write_strobe_n_o,
   input wire io_read_strobe_n_o,
   input wire io_write_strobe_n_o,
   input wire end_of_process_n_o,
   input wire end_of_process_n_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   AST_HOLD_ANSWER: assert property (!bus_hold_request_o && |request_pending_o |=> bus_hold_request_o)
      else $error("hold request late");
   AST_GRANT_WAIT: assert property ($rose(bus_hold_request_o) |-> !address_valid_enable_o [*2])
      else $error("grant wait too short");
   AST_ACK_IDLE: assert property (!address_valid_enable_o || command_i[0]
      |-> channel_acknowledge_o == {NCH{~command_i[7]}})
      else $error("acknowledge active wrongly");
   AST_ACK_ONE: assert property ($onehot0(channel_acknowledge_o ^ {NCH{~command_i[7]}}))
      else $error("several acknowledges");
   AST_RELEASE: assert property (!address_valid_enable_o
      |-> !(data_bus_pins_oe_o | strobe_oe_o | low_address_pins_oe_o))
      else $error("bus driven while not owner");
   AST_STB_AEN: assert property (upper_address_strobe_o
      |-> address_valid_enable_o && data_bus_pins_oe_o ##1 !upper_address_strobe_o)
      else $error("upper strobe wrong");
   AST_PAIR: assert property (strobe_oe_o |-> (memory_read_strobe_n_o | io_read_strobe_n_o)
      && (memory_write_strobe_n_o | io_write_strobe_n_o))
      else $error("strobe pairing wrong");
   AST_EOP_PULSE: assert property (end_of_process_n_oe_o |-> !end_of_process_n_o ##1 !end_of_process_n_oe_o)
      else $error("end pulse wrong");
endmodule
bind dts_sequencer dts_seq_props #(.NCH(NCH)) props_u (.*);

// ===== sim/dts_host_model.sv
// Purpose: host granting the bus, pull-up on the end line
// Assumes: grant follows hold request on rising edges
// Notes: slow mode stretches the grant delay
`timescale 1ns/1ps
// ==========
// host model
module dts_host_model (
   // bus hold
   input wire clk_i,
   input wire hold_request_i,
   input wire slow_i,
   output reg grant_o,
   // end of process line
   input wire eop_oe_i,
   input wire eop_drive_n_i,
   input wire ext_stop_i,
   output wire eop_n_o
);
   reg [2:0] wait_reg;
   always @(posedge clk_i) begin
      if (hold_request_i !== 1'b1) begin
         wait_reg <= 3'h0;
         grant_o <= 1'b0;
      end else begin
         // saturate at 7 so the wait count never wraps back to zero
         if (wait_reg != 3'h7) wait_reg <= wait_reg + 3'h1;
         // once given, the grant stands until hold request drops
         grant_o <= grant_o | (wait_reg >= (slow_i ? 3'h4 : 3'h1));
      end
   end
   // pull-up holds the line high unless sunk
   assign eop_n_o = ((eop_oe_i & ~eop_drive_n_i) | ext_stop_i) ? 1'b0 : 1'b1;
endmodule

// ===== sim/test_dma_transfer_sequencer.sv
// Purpose: self-checking bench for the sequencer
// Assumes: inputs driven on falling edges
// Notes: expected addresses queued per strobe start
`timescale 1ns/1ps
`include "dts_defines.vh"
module test_dma_transfer_sequencer;
   reg clk_i = 1'b0, srst_i = 1'b1, chip_select_n_i = 1'b1, ready_i = 1'b1, ext_stop = 1'b0, slow = 1'b0;
   reg [7:0] command_i = 8'h00, data_bus_pins_i = 8'h00, hi_q = 8'h00;
   reg [15:0] chan_mode_i = 16'h0000, load_addr_i = 16'h0000, load_count_i = 16'h0000;
   reg [3:0] mask_i = 4'h0, soft_request_i = 4'h0, load_i = 4'h0, channel_request_i = 4'h0;
   reg [3:0] low_address_pins_i = 4'h0;
   wire bus_hold_request_o, bus_hold_grant_i, program_state_o, low_address_pins_oe_o, mid_address_pins_oe_o;
   wire data_bus_pins_oe_o, address_valid_enable_o, upper_address_strobe_o, strobe_oe_o;
   wire memory_read_strobe_n_o, memory_write_strobe_n_o, io_read_strobe_n_o, io_write_strobe_n_o;
   wire end_of_process_n_i, end_of_process_n_o, end_of_process_n_oe_o;
   wire [3:0] channel_acknowledge_o, reg_select_o, low_address_pins_o, mid_address_pins_o;
   wire [3:0] terminal_count_o, request_pending_o;
   wire [7:0] data_bus_pins_o;
   integer fail_count = 0, checks_done = 0, cycles = 0, eops = 0, run_ch = 0;
   reg [31:0] seed = 32'h829bb1ec;
   reg [15:0] exp_q[$];
   reg vfy = 1'b0, was_low = 1'b0;
   wire any_low = strobe_oe_o & ~(memory_read_strobe_n_o & memory_write_strobe_n_o
      & io_read_strobe_n_o & io_write_strobe_n_o);
   dts_sequencer dut_u (.*);
   dts_host_model host_u (.clk_i(clk_i), .hold_request_i(bus_hold_request_o), .slow_i(slow),
      .grant_o(bus_hold_grant_i), .eop_oe_i(end_of_process_n_oe_o), .eop_drive_n_i(end_of_process_n_o),
      .ext_stop_i(ext_stop), .eop_n_o(end_of_process_n_i));
   initial forever #20 clk_i = ~clk_i;
   function [31:0] rnd(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         rnd = x ^ (x << 5);
      end
   endfunction
   task chk(input ok, input [8*20:1] msg);
      begin
         checks_done = checks_done + 1;
         if (ok !== 1'b1) begin
            $display("CHECK FAILED at %0t: %0s", $time, msg);
            fail_count = fail_count + 1;
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // ==========
   // monitor: one expected address per strobe start
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         summarize;
      end
      if (end_of_process_n_oe_o === 1'b1) eops = eops + 1;
      if (upper_address_strobe_o === 1'b1) hi_q = data_bus_pins_o;
      if (any_low === 1'b1 && !was_low) begin
         chk(!vfy && exp_q.size() > 0, "strobe unexpected");
         if (exp_q.size() > 0) chk({hi_q, mid_address_pins_o, low_address_pins_o} === exp_q.pop_front(), "address");
         chk((address_valid_enable_o & low_address_pins_oe_o & mid_address_pins_oe_o) === 1'b1,
            "bus enables");
         if (!command_i[0]) chk(channel_acknowledge_o[run_ch] === command_i[7], "acknowledge");
         if (command_i[0] && !memory_write_strobe_n_o) chk(data_bus_pins_o === data_bus_pins_i, "holding byte");
      end
      was_low = (any_low === 1'b1);
   end
   // ==========
   // one transfer run; mem2mem uses channel 1 at a + 0100
   task run(input integer ch, input [1:0] ty, input [7:0] cmd, input [15:0] a, input [15:0] n,
      input hw, input integer stop_at);
      integer i, k, e0;
      reg dec;
      begin
         @(negedge clk_i);
         dec = (ty == `DTS_XFER_WRITE);
         vfy = (ty == `DTS_XFER_VERIFY);
         run_ch = ch;
         command_i = cmd;
         chan_mode_i = {4{ty, dec, 1'b0}};
         data_bus_pins_i = seed[7:0];
         load_addr_i = cmd[0] ? a + 16'h0100 : a;
         load_count_i = n;
         load_i = cmd[0] ? 4'h2 : 4'h1 << ch;
         @(negedge clk_i);
         load_addr_i = a;
         load_i = cmd[0] ? 4'h1 : 4'h0;
         @(negedge clk_i);
         load_i = 4'h0;
         for (i = 0; i <= n && !vfy; i = i + 1) begin
            exp_q.push_back(cmd[1] ? a : (dec ? a - i : a + i));
            if (cmd[0]) exp_q.push_back(a + 16'h0100 + i);
         end
         e0 = eops;
         if (hw) channel_request_i[ch] = 1'b1;
         else soft_request_i[ch] = 1'b1;
         @(negedge clk_i);
         soft_request_i = 4'h0;
         repeat (3) @(negedge clk_i);
         k = 0;
         while (k < 3000 && (exp_q.size() != 0 || bus_hold_request_o !== 1'b0)) begin
            @(negedge clk_i);
            k = k + 1;
            seed = rnd(seed);
            ready_i = seed[9:8] != 2'h0;
            slow = seed[12];
            ext_stop = (stop_at != 0 && k >= stop_at && k < stop_at + 2);
            // demand-style continuation needs the request up until the count wraps
            if (terminal_count_o[ch] === 1'b1) channel_request_i[ch] = 1'b0;
         end
         // the end pulse is counted one edge after the return to idle
         repeat (2) @(negedge clk_i);
         chk(k < 3000 && exp_q.size() == 0, "run incomplete");
         chk(eops - e0 == (stop_at == 0), "end pulse count");
         if (!cmd[0] && stop_at == 0) chk(terminal_count_o[ch] === 1'b1, "terminal count");
         $display("run on channel %0d done", ch);
      end
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (16) @(negedge clk_i);
      srst_i = 1'b0;
      @(negedge clk_i);
      chk(channel_acknowledge_o === 4'hf && bus_hold_request_o === 1'b0, "reset acknowledge");
      chk(data_bus_pins_oe_o === 1'b0 && strobe_oe_o === 1'b0, "reset release");
      seed = rnd(seed);
      chip_select_n_i = 1'b0;
      low_address_pins_i = seed[3:0];
      #5 chk(program_state_o === 1'b1 && reg_select_o === seed[3:0], "programming");
      @(negedge clk_i);
      chip_select_n_i = 1'b1;
      run(2, `DTS_XFER_READ, 8'h20, 16'h12fe, 16'h0002, 1'b1, 0);
      run(1, `DTS_XFER_WRITE, 8'h88, 16'h3401, 16'h0001, 1'b0, 0);
      run(3, `DTS_XFER_VERIFY, 8'h00, 16'h0050, 16'h0003, 1'b0, 0);
      run(0, `DTS_XFER_READ, 8'h01, 16'h0400, 16'h0002, 1'b0, 0);
      run(0, `DTS_XFER_READ, 8'h03, 16'h0400, 16'h0001, 1'b0, 0);
      run(3, `DTS_XFER_VERIFY, 8'h00, 16'h0000, 16'h00ff, 1'b0, 12);
      summarize;
   end
endmodule
